// ==== hdl/eamgc_top.sv ====
// Accumulation mode, sign and fault events and input gain registers.
// Assumes power samples and pulse strobes on the core clock.
`timescale 1ns/100ps
module eamgc_top #(
  parameter int PWR_W = eamgc_pkg::PWR_W
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [eamgc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic power_valid_in,
  input wire logic signed [PWR_W-1:0] active_power_in,
  input wire logic signed [PWR_W-1:0] reactive_power_in,
  input wire logic active_pulse_in,
  input wire logic reactive_pulse_in,
  input wire logic pulse_on_reactive_in,
  input wire logic antitamper_in,
  input wire logic current_input_b_in,
  input wire logic fault_mode_in,
  output logic accum_valid_out,
  output logic signed [PWR_W-1:0] active_accum_out,
  output logic signed [PWR_W-1:0] reactive_accum_out,
  output logic signed [PWR_W-1:0] pulse_accum_out,
  output logic [2:0] voltage_input_gain_out,
  output logic [2:0] current_input_gain_out,
  output logic irq_out
);
  logic [7:0] acc_mode_q;
  logic [7:0] gain_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_stat_d;
  logic [7:0] irq_mask_q;
  logic [7:0] rdata_q;
  logic cur_in_q;
  logic [2:0] cur_sync_q;
  logic [2:0] fault_sync_q;
  logic fault_state_q;
  logic accum_valid_q;
  logic signed [PWR_W-1:0] act_acc_q;
  logic signed [PWR_W-1:0] react_acc_q;
  logic signed [PWR_W-1:0] pulse_acc_q;

  // Register decode
  wire wr_acc = reg_wr_in && reg_addr_in == eamgc_pkg::ACC_MODE_OFS;
  wire wr_gain = reg_wr_in && reg_addr_in == eamgc_pkg::GAIN_OFS;
  wire wr_stat = reg_wr_in && reg_addr_in == eamgc_pkg::IRQ_STAT_OFS;
  wire wr_mask = reg_wr_in && reg_addr_in == eamgc_pkg::IRQ_MASK_OFS;

  // Mode fields
  wire fault_pol = acc_mode_q[eamgc_pkg::ACC_FAULT_POL];
  wire rsign_sel = acc_mode_q[eamgc_pkg::ACC_RSIGN_SEL];
  wire asign_sel = acc_mode_q[eamgc_pkg::ACC_ASIGN_SEL];
  wire r_abs = acc_mode_q[eamgc_pkg::ACC_R_ABS];
  wire r_by_act = acc_mode_q[eamgc_pkg::ACC_R_BY_ACT];
  wire a_pos = acc_mode_q[eamgc_pkg::ACC_A_POS];
  wire a_abs = acc_mode_q[eamgc_pkg::ACC_A_ABS];
  wire sign_src = gain_q[eamgc_pkg::GAIN_SIGN_SRC];

  // Readback; bit 7 of mode is live status, not stored
  wire [7:0] acc_view = {cur_in_q, acc_mode_q[6:0]}; // R1
  wire [7:0] rd_mux =
    (reg_addr_in == eamgc_pkg::ACC_MODE_OFS) ? acc_view :
    (reg_addr_in == eamgc_pkg::GAIN_OFS) ? gain_q :
    (reg_addr_in == eamgc_pkg::IRQ_STAT_OFS) ? irq_stat_q :
    (reg_addr_in == eamgc_pkg::IRQ_MASK_OFS) ? irq_mask_q : 8'h00;

  // Active shaping: absolute wins over positive-only if both set
  wire act_neg = active_power_in[PWR_W-1];
  wire react_neg = reactive_power_in[PWR_W-1];
  wire signed [PWR_W-1:0] act_mag = act_neg ? -active_power_in
                                            : active_power_in;
  wire signed [PWR_W-1:0] react_mag = react_neg ? -reactive_power_in
                                                : reactive_power_in;
  wire signed [PWR_W-1:0] act_shaped =
    a_abs ? act_mag : // R9
    (a_pos && act_neg) ? '0 : // R8
    active_power_in;
  // Reactive shaping: absolute wins over signed-by-active
  wire signed [PWR_W-1:0] react_shaped =
    r_abs ? react_mag : // R5
    (r_by_act && act_neg) ? -reactive_power_in : // R6
    reactive_power_in;

  // Sign detection sources: filtered samples or per pulse
  wire a_sample = sign_src ? active_pulse_in : power_valid_in; // R11
  wire r_sample = sign_src ? reactive_pulse_in : power_valid_in; // R11
  wire asign_ev;
  wire rsign_ev;

  eamgc_sign_edge u_act_edge (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .sample_in(a_sample),
    .neg_in(act_neg),
    .rising_sel_in(asign_sel), // R4
    .event_out(asign_ev)
  );

  eamgc_sign_edge u_react_edge (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .sample_in(r_sample),
    .neg_in(react_neg),
    .rising_sel_in(rsign_sel), // R3
    .event_out(rsign_ev)
  );

  // Fault event: 0 on entering fault, 1 on return to normal
  wire fault_now = fault_sync_q[2] & fault_sync_q[1];
  wire fault_calm = ~fault_sync_q[2] & ~fault_sync_q[1];
  wire fault_enter = ~fault_state_q & fault_now;
  wire fault_leave = fault_state_q & fault_calm;
  wire fault_ev = fault_pol ? fault_leave : fault_enter; // R2

  // Sticky status: set beats write-one-to-clear
  wire [7:0] ev_vec = {5'h00, fault_ev, rsign_ev, asign_ev};
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_stat) begin
      irq_stat_d = irq_stat_d & ~reg_wdata_in;
    end
    irq_stat_d = (irq_stat_d | ev_vec) & eamgc_pkg::IRQ_USED_MASK; // R13 R14
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);
  assign reg_rdata_out = rdata_q;
  assign voltage_input_gain_out = gain_q[7:5]; // R10
  assign current_input_gain_out = gain_q[2:0]; // R12
  assign accum_valid_out = accum_valid_q;
  assign active_accum_out = act_acc_q;
  assign reactive_accum_out = react_acc_q;
  assign pulse_accum_out = pulse_acc_q;

  // Configuration registers; reserved bits stay zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_mode_q <= eamgc_pkg::ACC_RESET; // R16
      gain_q <= eamgc_pkg::GAIN_RESET;
      irq_mask_q <= 8'h00;
    end else begin
      if (wr_acc) acc_mode_q <= reg_wdata_in & eamgc_pkg::ACC_RW_MASK;
      if (wr_gain) gain_q <= reg_wdata_in & eamgc_pkg::GAIN_RW_MASK;
      if (wr_mask) irq_mask_q <= reg_wdata_in & eamgc_pkg::IRQ_USED_MASK;
    end
  end

  // Status, read data and synchronisers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_stat_q <= 8'h00;
      rdata_q <= 8'h00;
      cur_sync_q <= 3'h0;
      fault_sync_q <= 3'h0;
      cur_in_q <= 1'b0;
      fault_state_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      rdata_q <= reg_rd_in ? rd_mux : 8'h00;
      cur_sync_q <= {cur_sync_q[1:0], current_input_b_in};
      fault_sync_q <= {fault_sync_q[1:0], fault_mode_in};
      if (fault_now | fault_calm) fault_state_q <= fault_sync_q[2];
      // Channel shown only in antitamper mode, else input A
      if (cur_sync_q[2] == cur_sync_q[1]) begin
        cur_in_q <= antitamper_in & cur_sync_q[2]; // R1
      end
    end
  end

  // Shaped samples: the reactive register and pulse share one path when pulse_on_reactive_in is set
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      accum_valid_q <= 1'b0;
      act_acc_q <= '0;
      react_acc_q <= '0;
      pulse_acc_q <= '0;
    end else begin
      accum_valid_q <= power_valid_in;
      if (power_valid_in) begin
        act_acc_q <= act_shaped;
        react_acc_q <= react_shaped; // R7
        pulse_acc_q <= pulse_on_reactive_in ? react_shaped // R7
                                            : act_shaped;
      end
    end
  end

  // Assertions
  property p_abs_act;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      power_valid_in && a_abs |=> !act_acc_q[PWR_W-1] ||
        act_acc_q == {1'b1, {(PWR_W-1){1'b0}}};
  endproperty
  abs_active_a: assert property (p_abs_act) // R9
    else $error("active absolute output negative");
  pos_only_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      power_valid_in && !a_abs && a_pos && act_neg |=> act_acc_q == 0) // R8
    else $error("negative active kept in positive-only");
  react_flip_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      power_valid_in && !r_abs && r_by_act && act_neg
      |=> react_acc_q == -$past(reactive_power_in)) // R6
    else $error("reactive not inverted for negative active");
  react_abs_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      power_valid_in && r_abs |=> react_acc_q == $past(react_mag)) // R5
    else $error("reactive magnitude wrong");
  pulse_react_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      power_valid_in && pulse_on_reactive_in |=> pulse_acc_q == react_acc_q) // R7
    else $error("pulse path differs from reactive register");
  gain_fields_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      wr_gain |=> voltage_input_gain_out == $past(reg_wdata_in[7:5]) &&
      current_input_gain_out == $past(reg_wdata_in[2:0])) // R10 R12
    else $error("gain field not taken from write");
  sign_flag_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      asign_ev |=> irq_stat_q[eamgc_pkg::IRQ_ASIGN]) // R13
    else $error("active sign event lost");
  fault_flag_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      fault_ev |=> irq_stat_q[eamgc_pkg::IRQ_FAULT] ##1 // R14
      irq_stat_q[eamgc_pkg::IRQ_FAULT] || $past(wr_stat))
    else $error("fault event lost");
  fault_dir_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      fault_ev |-> (fault_pol ? fault_state_q : !fault_state_q)) // R2
    else $error("fault event on wrong transition");
  mode_reset_a: assert property (@(posedge clk_sys_in)
      $rose(nrst_in) |-> acc_mode_q == 8'h00) // R16
    else $error("mode register not cleared by reset");
  gain_reset_a: assert property (@(posedge clk_sys_in) // R16
      $rose(nrst_in) |-> gain_q == eamgc_pkg::GAIN_RESET &&
      irq_stat_q == 8'h00)
    else $error("gain or status not cleared by reset");

  // Current input report: pin is trusted only once the synchroniser agrees
  cur_follow_a: assert property (@(posedge clk_sys_in) // R1
      disable iff (!nrst_in)
      antitamper_in && cur_sync_q[2] && cur_sync_q[1] |=> cur_in_q)
    else $error("current input b not reported");
  cur_clear_a: assert property (@(posedge clk_sys_in) // R1
      disable iff (!nrst_in)
      !antitamper_in && cur_sync_q[2] == cur_sync_q[1] |=> !cur_in_q)
    else $error("current input shown outside antitamper");
  mode_ro_a: assert property (@(posedge clk_sys_in) // R1
      disable iff (!nrst_in)
      wr_acc |=> !acc_mode_q[eamgc_pkg::ACC_CUR_IN])
    else $error("status bit stored from software write");
  rdata_mode_a: assert property (@(posedge clk_sys_in) // R1
      disable iff (!nrst_in)
      reg_rd_in && reg_addr_in == eamgc_pkg::ACC_MODE_OFS
      |=> reg_rdata_out == $past(acc_view))
    else $error("mode readback wrong");

  // Read data stands one cycle only, so a stale value cannot be misread
  rdata_idle_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  gain_rsvd_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      !gain_q[4])
    else $error("reserved gain bit set");
  flag_rsvd_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      irq_stat_q[7:3] == 5'h00 &&
      (irq_mask_q & ~eamgc_pkg::IRQ_USED_MASK) == 8'h00)
    else $error("unused status or mask bit set");

  // Sign events must match the selected direction
  asign_dir_a: assert property (@(posedge clk_sys_in) // R4
      disable iff (!nrst_in)
      asign_ev |-> (asign_sel ? !act_neg : act_neg))
    else $error("active sign event on wrong turn");
  rsign_dir_a: assert property (@(posedge clk_sys_in) // R3
      disable iff (!nrst_in)
      rsign_ev |-> (rsign_sel ? !react_neg : react_neg))
    else $error("reactive sign event on wrong turn");
  rsign_flag_a: assert property (@(posedge clk_sys_in) // R13
      disable iff (!nrst_in)
      rsign_ev |=> irq_stat_q[eamgc_pkg::IRQ_RSIGN])
    else $error("reactive sign event lost");
  pulse_src_a: assert property (@(posedge clk_sys_in) // R11
      disable iff (!nrst_in)
      sign_src && !active_pulse_in && !reactive_pulse_in
      |-> !asign_ev && !rsign_ev)
    else $error("sign event without pulse");
  filt_src_a: assert property (@(posedge clk_sys_in) // R11
      disable iff (!nrst_in)
      !sign_src && !power_valid_in |-> !asign_ev && !rsign_ev)
    else $error("sign event without filtered sample");

  // Fault transitions and write-one-to-clear
  fault_enter_a: assert property (@(posedge clk_sys_in) // R2
      disable iff (!nrst_in)
      !fault_pol && !fault_state_q && fault_now |-> fault_ev)
    else $error("fault entry event missed");
  fault_leave_a: assert property (@(posedge clk_sys_in) // R2
      disable iff (!nrst_in)
      fault_pol && fault_state_q && fault_calm |-> fault_ev)
    else $error("normal entry event missed");
  flag_clear_a: assert property (@(posedge clk_sys_in) // R14
      disable iff (!nrst_in)
      wr_stat && reg_wdata_in[eamgc_pkg::IRQ_FAULT] && !fault_ev
      |=> !irq_stat_q[eamgc_pkg::IRQ_FAULT])
    else $error("fault flag not cleared by write");

  // Datapath timing and plain accumulation
  accum_valid_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      power_valid_in |=> accum_valid_out)
    else $error("accumulate valid missing");
  accum_hold_a: assert property (@(posedge clk_sys_in)
      disable iff (!nrst_in)
      !power_valid_in |=> !accum_valid_out && $stable(act_acc_q) &&
      $stable(react_acc_q) && $stable(pulse_acc_q))
    else $error("shaped output moved without sample");
  act_plain_a: assert property (@(posedge clk_sys_in) // R8
      disable iff (!nrst_in)
      power_valid_in && !a_abs && !a_pos
      |=> act_acc_q == $past(active_power_in))
    else $error("signed active not passed unchanged");
  react_plain_a: assert property (@(posedge clk_sys_in) // R6
      disable iff (!nrst_in)
      power_valid_in && !r_abs && !(r_by_act && act_neg)
      |=> react_acc_q == $past(reactive_power_in))
    else $error("reactive changed for positive active");
  pulse_act_a: assert property (@(posedge clk_sys_in) // R7
      disable iff (!nrst_in)
      power_valid_in && !pulse_on_reactive_in |=> pulse_acc_q == act_acc_q)
    else $error("pulse path differs from active register");

  cover_sign_c: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
      rsign_ev ##[1:20] irq_out);
  cover_fault_c: cover property (@(posedge clk_sys_in)
      disable iff (!nrst_in) fault_ev && fault_pol);
  cover_pulse_c: cover property (@(posedge clk_sys_in)
      disable iff (!nrst_in) sign_src && asign_ev);
  cover_tamper_c: cover property (@(posedge clk_sys_in)
      disable iff (!nrst_in) cur_in_q);
  cover_rabs_c: cover property (@(posedge clk_sys_in)
      disable iff (!nrst_in) power_valid_in && r_abs && react_neg);
endmodule : eamgc_top

// ==== hdl/eamgc_pkg.sv ====
// Package for the energy accumulation mode and gain configuration block.
// Assumes one core clock and a plain strobe register port.
// What this block does
// R1 - Bit 7 reports current input in use
// R2 - Fault event polarity picks fault trigger edge
// R3 - Reactive sign select picks transition direction
// R4 - Active sign select picks transition direction
// R5 - Reactive absolute mode accumulates magnitude
// R6 - Reactive sign follows active power sign
// R7 - Reactive mode feeds reactive register and pulse
// R8 - Active positive-only drops negative power
// R9 - Active absolute mode accumulates magnitude
// R10 - Voltage gain field bits 7 to 5
// R11 - Sign detect on filtered power or pulse
// R12 - Current gain field bits 2 to 0
// R13 - Sign events set sticky status flags
// R14 - Fault transition sets sticky status flag
// R15 - Software writes only gain codes 0 to 4; the block stores codes 5 to 7 unchecked
// R16 - Mode register clears to zero on reset
package eamgc_pkg;
  localparam int ADDR_W = 8;
  localparam int PWR_W = 24;
  localparam logic [7:0] ACC_MODE_OFS = 8'h0F;
  localparam logic [7:0] GAIN_OFS = 8'h1B;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h41;
  localparam int ACC_CUR_IN = 7;
  localparam int ACC_FAULT_POL = 6;
  localparam int ACC_RSIGN_SEL = 5;
  localparam int ACC_ASIGN_SEL = 4;
  localparam int ACC_R_ABS = 3;
  localparam int ACC_R_BY_ACT = 2;
  localparam int ACC_A_POS = 1;
  localparam int ACC_A_ABS = 0;
  localparam int GAIN_SIGN_SRC = 3;
  localparam logic [7:0] GAIN_RW_MASK = 8'hEF;
  localparam logic [7:0] ACC_RW_MASK = 8'h7F;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
  localparam int IRQ_ASIGN = 0;
  localparam int IRQ_RSIGN = 1;
  localparam int IRQ_FAULT = 2;
  localparam logic [7:0] IRQ_USED_MASK = 8'h07;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eamgc_bus_type;

  typedef struct packed {
    logic signed [PWR_W-1:0] active;
    logic signed [PWR_W-1:0] reactive;
  } eamgc_power_type;
endpackage : eamgc_pkg

// ==== hdl/eamgc_sign_edge.sv ====
// Sign transition detector for one power quantity.
// Assumes sign and strobe inputs are on the core clock.
`timescale 1ns/100ps
module eamgc_sign_edge (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic sample_in,
  input wire logic neg_in,
  input wire logic rising_sel_in,
  output logic event_out
);
  logic last_neg_q;
  logic valid_q;
  wire went_neg = sample_in & valid_q & ~last_neg_q & neg_in;
  wire went_pos = sample_in & valid_q & last_neg_q & ~neg_in;

  // Select 0 flags positive to negative, 1 negative to positive
  assign event_out = rising_sel_in ? went_pos : went_neg;

  // First sample only primes history so reset never fakes an edge
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_neg_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (sample_in) begin
      last_neg_q <= neg_in;
      valid_q <= 1'b1;
    end
  end
endmodule : eamgc_sign_edge

// ==== tb/eamgc_top_test.sv ====
// Self-checking testbench for the accumulation mode and gain block.
// Assumes eamgc_pkg and eamgc_top are compiled before this file.
`timescale 1ns/100ps
module eamgc_top_test;
  typedef struct packed {
    logic [7:0] mode;
    logic signed [23:0] a, r;
    logic por;
    logic signed [23:0] ea, er, ep;
  } eamgc_row_type;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, pv = 1'b0, ap = 1'b0, rp = 1'b0;
  logic por = 1'b0, at = 1'b0, cib = 1'b0, flt = 1'b0;
  logic signed [23:0] act = 24'sh0000, rea = 24'sh0000, aa, ra, pa;
  logic av, irq;
  logic [2:0] vg, cg;
  int bad_count = 0, n_tests = 0;
  // Shaping cases: mode, active, reactive, pulse source, expected outputs
  eamgc_row_type rows [9] = '{
    '{8'h00, -24'sh0005, -24'sh0007, 1'b0, -24'sh0005, -24'sh0007, -24'sh0005},
    '{8'h01, -24'sh0005, -24'sh0007, 1'b0, 24'sh0005, -24'sh0007, 24'sh0005},
    '{8'h02, -24'sh0005, 24'sh0003, 1'b0, 24'sh0000, 24'sh0003, 24'sh0000},
    '{8'h02, 24'sh0006, 24'sh0003, 1'b0, 24'sh0006, 24'sh0003, 24'sh0006},
    '{8'h03, -24'sh0005, 24'sh0003, 1'b0, 24'sh0005, 24'sh0003, 24'sh0005},
    '{8'h08, 24'sh0002, -24'sh0007, 1'b1, 24'sh0002, 24'sh0007, 24'sh0007},
    '{8'h04, -24'sh0002, 24'sh0007, 1'b1, -24'sh0002, -24'sh0007, -24'sh0007},
    '{8'h04, 24'sh0002, -24'sh0007, 1'b1, 24'sh0002, -24'sh0007, -24'sh0007},
    '{8'h0C, -24'sh0002, -24'sh0007, 1'b1, -24'sh0002, 24'sh0007, 24'sh0007}};

  eamgc_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .power_valid_in(pv),
    .active_power_in(act), .reactive_power_in(rea),
    .active_pulse_in(ap), .reactive_pulse_in(rp),
    .pulse_on_reactive_in(por), .antitamper_in(at),
    .current_input_b_in(cib), .fault_mode_in(flt),
    .accum_valid_out(av), .active_accum_out(aa),
    .reactive_accum_out(ra), .pulse_accum_out(pa),
    .voltage_input_gain_out(vg), .current_input_gain_out(cg),
    .irq_out(irq));

  // 100 ns period core clock
  always #50 clk_sys_in = ~clk_sys_in;

  task automatic chk(input logic [23:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk

  // Register port master: one strobe cycle, released on the next edge
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data is only valid in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, e, input string m);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk({16'h0000, rdata}, {16'h0000, e}, m);
  endtask : rd_chk

  task automatic sample(input logic signed [23:0] a, r, input logic p);
    @(posedge clk_sys_in);
    act <= a;
    rea <= r;
    pv <= !p;
    ap <= p;
    rp <= p;
    @(posedge clk_sys_in);
    pv <= 1'b0;
    ap <= 1'b0;
    rp <= 1'b0;
    #1;
  endtask : sample

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : wait_n

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(100 * 20000);
    bad_count++;
    stop_test();
  end

  initial begin
    wait_n(4);
    nrst_in <= 1'b1;
    rd_chk(8'h0F, 8'h00, "mode reset");
    rd_chk(8'h1B, 8'h00, "gain reset");
    rd_chk(8'h40, 8'h00, "status reset");
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk_sys_in);
      por <= rows[i].por;
      wr_reg(8'h0F, rows[i].mode);
      sample(rows[i].a, rows[i].r, 1'b0);
      chk({23'h00_0000, av}, 24'h00_0001, "accum valid");
      chk(aa, rows[i].ea, "active shaped");
      chk(ra, rows[i].er, "reactive shaped");
      chk(pa, rows[i].ep, "pulse shaped");
    end
    $display("test shaping done");
    // Sign events in both directions; the opposite turn must stay quiet
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'h0F, s ? 8'h30 : 8'h00);
      sample(s ? -100 : 100, s ? -100 : 100, 1'b0);
      wr_reg(8'h40, 8'hFF);
      sample(s ? 100 : -100, s ? 100 : -100, 1'b0);
      wait_n(2);
      rd_chk(8'h40, 8'h03, "sign event");
      wr_reg(8'h40, 8'hFF);
      sample(s ? -100 : 100, s ? -100 : 100, 1'b0);
      wait_n(2);
      rd_chk(8'h40, 8'h00, "wrong turn");
    end
    // Pulse based detection ignores filtered samples
    wr_reg(8'h0F, 8'h00);
    wr_reg(8'h1B, 8'h08);
    sample(100, 100, 1'b0);
    wr_reg(8'h40, 8'hFF);
    sample(-100, -100, 1'b0);
    wait_n(2);
    rd_chk(8'h40, 8'h00, "filtered ignored");
    sample(100, 100, 1'b1);
    wr_reg(8'h40, 8'hFF);
    sample(-100, -100, 1'b1);
    wait_n(2);
    rd_chk(8'h40, 8'h03, "pulse sign");
    $display("test sign done");
    for (int c = 0; c < 5; c++) begin
      wr_reg(8'h1B, {c[2:0], 2'b10, 3'(4 - c)});
      rd_chk(8'h1B, {c[2:0], 2'b00, 3'(4 - c)}, "gain read");
      chk({21'h00_0000, vg}, 24'(c), "voltage gain");
      chk({21'h00_0000, cg}, 24'(4 - c), "current gain");
    end
    $display("test gain done");
    // Fault entry and exit under both polarities, with the interrupt
    wr_reg(8'h40, 8'hFF);
    @(posedge clk_sys_in);
    flt <= 1'b1;
    wait_n(6);
    rd_chk(8'h40, 8'h04, "fault entry");
    wr_reg(8'h41, 8'h04);
    wait_n(2);
    chk({23'h00_0000, irq}, 24'h00_0001, "irq on");
    wr_reg(8'h41, 8'h00);
    wait_n(2);
    chk({23'h00_0000, irq}, 24'h00_0000, "irq masked");
    wr_reg(8'h40, 8'hFF);
    @(posedge clk_sys_in);
    flt <= 1'b0;
    wait_n(6);
    rd_chk(8'h40, 8'h00, "fault exit quiet");
    wr_reg(8'h0F, 8'h40);
    @(posedge clk_sys_in);
    flt <= 1'b1;
    wait_n(6);
    rd_chk(8'h40, 8'h00, "fault entry quiet");
    @(posedge clk_sys_in);
    flt <= 1'b0;
    wait_n(6);
    rd_chk(8'h40, 8'h04, "normal entry");
    $display("test fault done");
    // Current input bit is read only and follows the pin in antitamper
    wr_reg(8'h0F, 8'h80);
    rd_chk(8'h0F, 8'h00, "input bit ro");
    @(posedge clk_sys_in);
    at <= 1'b1;
    cib <= 1'b1;
    wait_n(6);
    rd_chk(8'h0F, 8'h80, "input b");
    @(posedge clk_sys_in);
    cib <= 1'b0;
    wait_n(6);
    rd_chk(8'h0F, 8'h00, "input a");
    rd_chk(8'h20, 8'h00, "unmapped");
    $display("test input done");
    stop_test();
  end
endmodule : eamgc_top_test
